/* File: tb/ldr_far_model.sv */
/*
 * Far-side model: the two lookup-table arrays seen by the register bank.
 * Assumes row contents are a fixed pattern of the row address, so that a
 * wrong row shows up as a wrong DAC code.
 */
`timescale 1ns/100ps

module ldr_far_model
   import ldr_pkg::*;
(
   // Row addresses from the bank
   input wire ldr_drive_s drive,
   // Row contents back to the bank
   output logic [7:0] first_lookup_table_row_data,
   output logic [7:0] second_lookup_table_row_data
);
   // Distinct patterns per table catch crossed rows
   assign first_lookup_table_row_data = drive.row1[7:0] ^ 8'h5A;
   assign second_lookup_table_row_data = drive.row2[7:0] ^ 8'hA5;
endmodule

/* File: tb/ldr_regs_test.sv */
/*
 * Self-checking bench for the direct-access register bank.
 * Assumes the bank answers one edge after a strobe and that its drive
 * outputs settle within three edges of any input change.
 */
`timescale 1ns/100ps

module ldr_regs_test
   import ldr_pkg::*;
;
   logic core_clk, rst, gen2_dir, persist, rst_v;
   logic [5:0] conv;
   logic [7:0] l1, l2;
   ldr_req_s req;
   ldr_ctl_s rctl;
   ldr_resp_s resp;
   ldr_nv_s nv;
   ldr_drive_s drv;
   logic wpl;
   int n_errors = 0;
   int comparisons = 0;

   ldr_regs u_ldr_regs (.core_clk(core_clk), .rst(rst), .mm_req(req),
      .mm_resp(resp), .gen2_direction_select(gen2_dir),
      .control_bytes_persistence(persist), .converter_result_bits(conv),
      .first_lookup_table_row_data(l1), .second_lookup_table_row_data(l2), .restore_valid(rst_v),
      .restore_ctl(rctl), .nv_wr(nv), .drive(drv),
      .write_permit_latch(wpl));
   ldr_far_model u_ldr_far_model (.drive(drv), .first_lookup_table_row_data(l1),
      .second_lookup_table_row_data(l2));

   // ************************************************************
   // Helpers
   // ************************************************************
   task chk(input logic [16:0] got, input logic [16:0] exp, input string m);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask

   // One byte access; e is the expected {ack, nack}
   task acc(input logic w, input logic [7:0] a, input logic [7:0] d,
            input logic [1:0] e, input logic [7:0] rd);
      @(posedge core_clk);
      req.wr <= w;
      req.rd <= !w;
      req.addr <= a;
      req.wdata <= d;
      @(posedge core_clk);
      req.wr <= 1'b0;
      req.rd <= 1'b0;
      #1;
      chk({resp.ack, resp.nack}, e, "response");
      if (!w) chk(resp.rdata, rd, "read data");
   endtask

   // Row codes pass through one register stage, DAC codes taken from rows through two
   task settle;
      repeat (3) @(posedge core_clk);
      #1;
   endtask

   task wrap_up;
      $display("comparisons %0d errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // ************************************************************
   // Scenarios
   // ************************************************************
   task t_reset;
      settle;
      chk(wpl, 1'b0, "latch after reset");
      chk(drv.row1, 9'h090, "row1 after reset");
      chk(drv.row2, 9'h0D0, "row2 after reset");
      chk(drv.gen2_sink, 1'b0, "source by default");
   endtask

   task t_locked;
      acc(1, LDR_ADDR_FIRST_CURRENT_CONVERTER, 8'h77, 2'b01, 0);
      chk(nv.wr, 1'b0, "no store when locked");
      acc(0, LDR_ADDR_FIRST_CURRENT_CONVERTER, 0, 2'b10, 8'h00);
      acc(1, LDR_ADDR_WEN, 8'h80, 2'b10, 0);
      chk(wpl, 1'b1, "latch set");
      acc(0, LDR_ADDR_WEN, 0, 2'b10, 8'h80);
   endtask

   task t_regs;
      @(posedge core_clk);
      persist <= 1'b0;
      acc(1, LDR_ADDR_ROW1, 8'h3F, 2'b10, 0);
      chk(nv.wr, 1'b0, "volatile index");
      acc(0, LDR_ADDR_ROW1, 0, 2'b10, 8'h3F);
      acc(1, LDR_ADDR_ROW2, 8'h3F, 2'b10, 0);
      acc(0, LDR_ADDR_ROW2, 0, 2'b10, 8'h3F);
      @(posedge core_clk);
      persist <= 1'b1;
      acc(1, LDR_ADDR_FIRST_CURRENT_CONVERTER, 8'hC3, 2'b10, 0);
      chk({nv.wr, nv.addr, nv.data}, {1'b1, 8'h83, 8'hC3}, "nv");
      acc(0, LDR_ADDR_FIRST_CURRENT_CONVERTER, 0, 2'b10, 8'hC3);
      acc(1, LDR_ADDR_SECOND_CURRENT_CONVERTER, 8'h3C, 2'b10, 0);
      acc(0, LDR_ADDR_SECOND_CURRENT_CONVERTER, 0, 2'b10, 8'h3C);
      @(posedge core_clk);
      persist <= 1'b0;
      acc(1, LDR_ADDR_SEL, 8'hFF, 2'b10, 0);
      chk({nv.wr, nv.addr}, {1'b1, 8'h85}, "select stored");
      acc(0, LDR_ADDR_SEL, 0, 2'b10, 8'hFF);
   endtask

   task t_select;
      @(posedge core_clk);
      conv <= 6'h15;
      acc(1, LDR_ADDR_SEL, 8'hF0, 2'b10, 0);
      settle;
      chk(drv.row1, 9'h0CF, "row1 index 3F");
      chk(drv.row2, 9'h10F, "row2 index 3F");
      chk(drv.first_current_converter, 8'hC3, "first_current_converter direct");
      chk(drv.second_current_converter, 8'h3C, "second_current_converter direct");
      acc(1, LDR_ADDR_SEL, 8'h50, 2'b10, 0);
      settle;
      chk(drv.first_current_converter, 8'hCF ^ 8'h5A, "first_current_converter from row");
      chk(drv.second_current_converter, 8'h0F ^ 8'hA5, "second_current_converter from row");
      acc(1, LDR_ADDR_SEL, 8'h00, 2'b10, 0);
      settle;
      chk(drv.row1, 9'h0A5, "row1 converter");
      chk(drv.row2, 9'h0E5, "row2 converter");
      @(posedge core_clk);
      conv <= 6'h3F;
      settle;
      chk(drv.row1, 9'h0CF, "row1 follows");
      chk(drv.second_current_converter, 8'h0F ^ 8'hA5, "second_current_converter follows");
   endtask

   task t_status;
      acc(0, LDR_ADDR_STAT, 0, 2'b10, 8'hFC);
      @(posedge core_clk);
      conv <= 6'h2A;
      settle;
      acc(0, LDR_ADDR_STAT, 0, 2'b10, 8'hA8);
      acc(1, LDR_ADDR_STAT, 8'h00, 2'b10, 0);
      acc(0, LDR_ADDR_STAT, 0, 2'b10, 8'hA8);
      acc(1, LDR_ADDR_RSV_LO, 8'h00, 2'b10, 0);
      acc(1, LDR_ADDR_RSV_HI, 8'h00, 2'b10, 0);
      acc(1, 8'h90, 8'h00, 2'b00, 0);
      @(posedge core_clk);
      gen2_dir <= 1'b1;
      settle;
      chk(drv.gen2_sink, 1'b1, "generator 2 sinks");
   endtask

   task t_relock;
      @(posedge core_clk);
      rctl <= {6'h01, 6'h02, 8'h5E, 8'h3C, 8'h00};
      rst_v <= 1'b1;
      @(posedge core_clk);
      rst_v <= 1'b0;
      acc(0, LDR_ADDR_FIRST_CURRENT_CONVERTER, 0, 2'b10, 8'h5E);
      acc(1, LDR_ADDR_WEN, 8'h00, 2'b10, 0);
      chk(wpl, 1'b0, "latch cleared");
      acc(1, LDR_ADDR_SECOND_CURRENT_CONVERTER, 8'h11, 2'b01, 0);
   endtask

   // ************************************************************
   // Sequence
   // ************************************************************
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   initial begin
      #100000;
      n_errors++;
      wrap_up;
   end

   initial begin
      rst = 1'b1;
      req = '0;
      rctl = '0;
      rst_v = 1'b0;
      gen2_dir = 1'b0;
      persist = 1'b0;
      conv = 6'h00;
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
      t_reset;
      t_locked;
      t_regs;
      t_select;
      t_status;
      t_relock;
      wrap_up;
   end
endmodule

/* File: verilog/ldr_pkg.sv */
/*
 * Shared constants and carrier types for the lookup-table / current DAC
 * direct-access register bank.
 * Assumes a byte-wide memory-map port that a serial-bus front end drives,
 * and one 100 MHz clock.
 */
package ldr_pkg;

   // ************************************************************
   // Byte addresses of the bank
   // ************************************************************
   localparam logic [7:0] LDR_ADDR_ROW1 = 8'h81;
   localparam logic [7:0] LDR_ADDR_ROW2 = 8'h82;
   localparam logic [7:0] LDR_ADDR_FIRST_CURRENT_CONVERTER = 8'h83;
   localparam logic [7:0] LDR_ADDR_SECOND_CURRENT_CONVERTER = 8'h84;
   localparam logic [7:0] LDR_ADDR_SEL = 8'h85;
   localparam logic [7:0] LDR_ADDR_WEN = 8'h86;
   localparam logic [7:0] LDR_ADDR_STAT = 8'h87;
   localparam logic [7:0] LDR_ADDR_RSV_LO = 8'h88;
   localparam logic [7:0] LDR_ADDR_RSV_HI = 8'h8F;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int LDR_BIT_T1_SEL = 4;
   localparam int LDR_BIT_D1_SEL = 5;
   localparam int LDR_BIT_T2_SEL = 6;
   localparam int LDR_BIT_D2_SEL = 7;
   localparam int LDR_BIT_WPL = 7;
   localparam int LDR_STAT_LSB = 2;
   localparam int LDR_IDX_W = 6;

   // ************************************************************
   // Table bases and reset values
   // ************************************************************
   localparam logic [8:0] LDR_T1_BASE = 9'h090;
   localparam logic [8:0] LDR_T2_BASE = 9'h0D0;
   localparam logic [7:0] LDR_RST_BYTE = 8'h00;
   localparam logic [5:0] LDR_RST_IDX = 6'h00;
   localparam logic LDR_RST_WPL = 1'b0;

   // ************************************************************
   // Carriers
   // ************************************************************
   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } ldr_req_s;

   typedef struct packed {
      logic [7:0] rdata;
      logic ack;
      logic nack;
   } ldr_resp_s;

   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [7:0] data;
   } ldr_nv_s;

   typedef struct packed {
      logic [5:0] idx1;
      logic [5:0] idx2;
      logic [7:0] first_current_converter;
      logic [7:0] second_current_converter;
      logic [7:0] sel;
   } ldr_ctl_s;

   typedef struct packed {
      logic [8:0] row1;
      logic [8:0] row2;
      logic [7:0] first_current_converter;
      logic [7:0] second_current_converter;
      logic gen2_sink;
   } ldr_drive_s;

endpackage

/* File: verilog/ldr_regs.sv */
/*
 * Direct-access register bank: table row selection, DAC input selection,
 * write-permit latch and converter status.
 * Assumes a serial-bus front end issues one-cycle read/write strobes on the
 * memory-map port, that a nonvolatile store accepts write pulses and can
 * replay stored bytes on the restore port after power-up, and that control
 * byte 0 lives elsewhere and hands in its direction and persistence bits.
 */
`timescale 1ns/100ps

module ldr_regs
   import ldr_pkg::*;
#(
   parameter int ADC_W = 6
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Memory-map port from the serial front end
   input wire ldr_req_s mm_req,
   output ldr_resp_s mm_resp,
   // Bits of control byte 0 held elsewhere
   input wire logic gen2_direction_select,
   input wire logic control_bytes_persistence,
   // Converter result and table rows read back from the arrays
   input wire logic [ADC_W-1:0] converter_result_bits,
   input wire logic [7:0] first_lookup_table_row_data,
   input wire logic [7:0] second_lookup_table_row_data,
   // Power-up replay of stored control bytes
   input wire logic restore_valid,
   input wire ldr_ctl_s restore_ctl,
   // Nonvolatile write request
   output ldr_nv_s nv_wr,
   // Analog side
   output ldr_drive_s drive,
   output logic write_permit_latch
);

   // ************************************************************
   // Elaboration check
   // ************************************************************
   if (ADC_W != LDR_IDX_W) begin : g_width_check
      $error("ldr_regs: converter width must equal the 6-bit row index");
   end

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      ldr_ctl_s ctl;
      logic wpl;
      ldr_resp_s resp;
      ldr_nv_s nv;
      ldr_drive_s drv;
      // Low on the edge that leaves reset; checks wait for it
      logic live;
   } ldr_state_s;

   ldr_state_s s_q;
   ldr_state_s s_d;

   // Row address within a table, used for both tables
   function automatic logic [8:0] row_addr(input logic [8:0] base,
                                           input logic [5:0] idx);
      row_addr = base + {3'h0, idx};
   endfunction

   function automatic logic in_bank(input logic [7:0] a);
      in_bank = (a >= LDR_ADDR_ROW1) && (a <= LDR_ADDR_RSV_HI);
   endfunction

   logic [5:0] adc6;
   assign adc6 = converter_result_bits;

   // ************************************************************
   // Next-state logic
   // ************************************************************
   always_comb begin
      logic permitted;
      logic [7:0] rd_byte;
      permitted = 1'b0;
      rd_byte = LDR_RST_BYTE;
      s_d = s_q;
      s_d.resp.ack = 1'b0;
      s_d.resp.nack = 1'b0;
      s_d.nv.wr = 1'b0;
      s_d.live = 1'b1;

      // Latch byte may always be written, else nothing could unlock
      permitted = (mm_req.addr == LDR_ADDR_WEN) || s_q.wpl;

      if (restore_valid) begin
         // Replay wins over host traffic in any cycle that restore_valid is high
         s_d.ctl = restore_ctl;
      end else if (mm_req.wr && in_bank(mm_req.addr)) begin
         if (!permitted) begin
            s_d.resp.nack = 1'b1;
         end else begin
            s_d.resp.ack = 1'b1;
            s_d.nv.addr = mm_req.addr;
            s_d.nv.data = mm_req.wdata;
            unique case (mm_req.addr)
               LDR_ADDR_ROW1: begin
                  s_d.ctl.idx1 = mm_req.wdata[5:0];
                  s_d.nv.wr = control_bytes_persistence;
                  s_d.nv.data = {2'h0, mm_req.wdata[5:0]};
               end
               LDR_ADDR_ROW2: begin
                  s_d.ctl.idx2 = mm_req.wdata[5:0];
                  s_d.nv.wr = control_bytes_persistence;
                  s_d.nv.data = {2'h0, mm_req.wdata[5:0]};
               end
               LDR_ADDR_FIRST_CURRENT_CONVERTER: begin
                  s_d.ctl.first_current_converter = mm_req.wdata;
                  s_d.nv.wr = control_bytes_persistence;
               end
               LDR_ADDR_SECOND_CURRENT_CONVERTER: begin
                  s_d.ctl.second_current_converter = mm_req.wdata;
                  s_d.nv.wr = control_bytes_persistence;
               end
               LDR_ADDR_SEL: begin
                  s_d.ctl.sel = mm_req.wdata;
                  s_d.nv.wr = 1'b1;
               end
               LDR_ADDR_WEN: begin
                  // Only the latch changes; reserved bits stay zero
                  s_d.wpl = mm_req.wdata[LDR_BIT_WPL];
               end
               default: begin
                  // Status is read-only, 88h..8Fh have no function
                  s_d.resp.ack = 1'b1;
               end
            endcase
         end
      end else if (mm_req.rd && in_bank(mm_req.addr)) begin
         unique case (mm_req.addr)
            LDR_ADDR_ROW1: rd_byte = {2'h0, s_q.ctl.idx1};
            LDR_ADDR_ROW2: rd_byte = {2'h0, s_q.ctl.idx2};
            LDR_ADDR_FIRST_CURRENT_CONVERTER: rd_byte = s_q.ctl.first_current_converter;
            LDR_ADDR_SECOND_CURRENT_CONVERTER: rd_byte = s_q.ctl.second_current_converter;
            LDR_ADDR_SEL: rd_byte = s_q.ctl.sel;
            LDR_ADDR_WEN: rd_byte = {s_q.wpl, 7'h00};
            LDR_ADDR_STAT: rd_byte = {adc6, 2'h0};
            default: rd_byte = LDR_RST_BYTE;
         endcase
         s_d.resp.rdata = rd_byte;
         s_d.resp.ack = 1'b1;
      end

      // Selections track every input each cycle, no trigger needed
      s_d.drv.row1 = row_addr(LDR_T1_BASE,
         s_d.ctl.sel[LDR_BIT_T1_SEL] ? s_d.ctl.idx1 : adc6);
      s_d.drv.row2 = row_addr(LDR_T2_BASE,
         s_d.ctl.sel[LDR_BIT_T2_SEL] ? s_d.ctl.idx2 : adc6);
      s_d.drv.first_current_converter = s_d.ctl.sel[LDR_BIT_D1_SEL] ?
         s_d.ctl.first_current_converter : first_lookup_table_row_data;
      s_d.drv.second_current_converter = s_d.ctl.sel[LDR_BIT_D2_SEL] ?
         s_d.ctl.second_current_converter : second_lookup_table_row_data;
      s_d.drv.gen2_sink = gen2_direction_select;
   end

   // ************************************************************
   // State register
   // ************************************************************
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_q.ctl.idx1 <= LDR_RST_IDX;
         s_q.ctl.idx2 <= LDR_RST_IDX;
         s_q.ctl.first_current_converter <= LDR_RST_BYTE;
         s_q.ctl.second_current_converter <= LDR_RST_BYTE;
         s_q.ctl.sel <= LDR_RST_BYTE;
         s_q.wpl <= LDR_RST_WPL;
         s_q.resp.rdata <= LDR_RST_BYTE;
         s_q.resp.ack <= 1'b0;
         s_q.resp.nack <= 1'b0;
         s_q.nv.wr <= 1'b0;
         s_q.nv.addr <= LDR_RST_BYTE;
         s_q.nv.data <= LDR_RST_BYTE;
         s_q.drv.row1 <= LDR_T1_BASE;
         s_q.drv.row2 <= LDR_T2_BASE;
         s_q.drv.first_current_converter <= LDR_RST_BYTE;
         s_q.drv.second_current_converter <= LDR_RST_BYTE;
         s_q.drv.gen2_sink <= 1'b0;
         s_q.live <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   assign mm_resp = s_q.resp;
   assign nv_wr = s_q.nv;
   assign drive = s_q.drv;
   assign write_permit_latch = s_q.wpl;

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge core_clk);
   endclocking
   // Reset is released on a clock edge; skip that edge's attempts
   default disable iff (rst || !s_q.live);

   gen2_polarity_a: assert property (
      ##1 drive.gen2_sink == $past(gen2_direction_select))
      else $error("generator 2 polarity does not follow direction bit");

   row1_index_a: assert property (
      s_q.ctl.sel[LDR_BIT_T1_SEL] |->
         drive.row1 == LDR_T1_BASE + {3'h0, s_q.ctl.idx1})
      else $error("first table row not taken from index");

   row2_range_a: assert property (
      drive.row2 >= LDR_T2_BASE && drive.row2 <= LDR_T2_BASE + 9'h03F)
      else $error("second table row outside its table");

   first_current_converter_direct_a: assert property (
      s_q.ctl.sel[LDR_BIT_D1_SEL] |-> drive.first_current_converter == s_q.ctl.first_current_converter)
      else $error("DAC 1 not driven from direct byte");

   second_current_converter_table_a: assert property (
      !s_d.ctl.sel[LDR_BIT_D2_SEL] |=> drive.second_current_converter == $past(second_lookup_table_row_data))
      else $error("DAC 2 not driven from table row");

   latch_write_a: assert property (
      mm_req.wr && !restore_valid && mm_req.addr == LDR_ADDR_WEN |=>
         write_permit_latch == $past(mm_req.wdata[LDR_BIT_WPL]) &&
         mm_resp.ack)
      else $error("write permit latch write not taken");

   locked_write_a: assert property (
      mm_req.wr && !restore_valid && !write_permit_latch &&
         in_bank(mm_req.addr) && mm_req.addr != LDR_ADDR_WEN |=>
         mm_resp.nack && !mm_resp.ack && !nv_wr.wr && $stable(s_q.ctl))
      else $error("write accepted while latch clear");

   persist_write_a: assert property (
      mm_req.wr && !restore_valid && write_permit_latch &&
         mm_req.addr == LDR_ADDR_FIRST_CURRENT_CONVERTER |=>
         nv_wr.wr == $past(control_bytes_persistence) &&
         nv_wr.addr == LDR_ADDR_FIRST_CURRENT_CONVERTER)
      else $error("direct byte persistence wrong");

   status_read_a: assert property (
      mm_req.rd && !mm_req.wr && !restore_valid &&
         mm_req.addr == LDR_ADDR_STAT |=>
         mm_resp.rdata == {$past(adc6), 2'h0} && mm_resp.ack)
      else $error("status read does not show converter result");

   reserved_read_a: assert property (
      mm_req.rd && !mm_req.wr && !restore_valid &&
         mm_req.addr >= LDR_ADDR_RSV_LO && mm_req.addr <= LDR_ADDR_RSV_HI
         |=> mm_resp.rdata == LDR_RST_BYTE)
      else $error("reserved address reads nonzero");

   row1_conv_a: assert property (
      !s_d.ctl.sel[LDR_BIT_T1_SEL] |=>
         drive.row1 == LDR_T1_BASE + {3'h0, $past(adc6)})
      else $error("first table row not taken from converter");

   row1_range_a: assert property (
      drive.row1 >= LDR_T1_BASE && drive.row1 <= LDR_T1_BASE + 9'h03F)
      else $error("first table row outside its table");

   row2_index_a: assert property (
      s_q.ctl.sel[LDR_BIT_T2_SEL] |->
         drive.row2 == LDR_T2_BASE + {3'h0, s_q.ctl.idx2})
      else $error("second table row not taken from index");

   row2_conv_a: assert property (
      !s_d.ctl.sel[LDR_BIT_T2_SEL] |=>
         drive.row2 == LDR_T2_BASE + {3'h0, $past(adc6)})
      else $error("second table row not taken from converter");

   first_current_converter_table_a: assert property (
      !s_d.ctl.sel[LDR_BIT_D1_SEL] |=> drive.first_current_converter == $past(first_lookup_table_row_data))
      else $error("DAC 1 not driven from table row");

   second_current_converter_direct_a: assert property (
      s_q.ctl.sel[LDR_BIT_D2_SEL] |-> drive.second_current_converter == s_q.ctl.second_current_converter)
      else $error("DAC 2 not driven from direct byte");

   index1_read_a: assert property (
      mm_req.rd && !mm_req.wr && !restore_valid &&
         mm_req.addr == LDR_ADDR_ROW1 |=>
         mm_resp.rdata == {2'h0, $past(s_q.ctl.idx1)} && mm_resp.ack)
      else $error("first index does not read back");

   index2_read_a: assert property (
      mm_req.rd && !mm_req.wr && !restore_valid &&
         mm_req.addr == LDR_ADDR_ROW2 |=>
         mm_resp.rdata == {2'h0, $past(s_q.ctl.idx2)} && mm_resp.ack)
      else $error("second index does not read back");

   first_current_converter_read_a: assert property (
      mm_req.rd && !mm_req.wr && !restore_valid &&
         mm_req.addr == LDR_ADDR_FIRST_CURRENT_CONVERTER |=>
         mm_resp.rdata == $past(s_q.ctl.first_current_converter) && mm_resp.ack)
      else $error("first direct byte does not read back");

   second_current_converter_write_a: assert property (
      mm_req.wr && !restore_valid && write_permit_latch &&
         mm_req.addr == LDR_ADDR_SECOND_CURRENT_CONVERTER |=>
         s_q.ctl.second_current_converter == $past(mm_req.wdata) && mm_resp.ack)
      else $error("second direct byte write not taken");

   select_store_a: assert property (
      mm_req.wr && !restore_valid && write_permit_latch &&
         mm_req.addr == LDR_ADDR_SEL |=>
         s_q.ctl.sel == $past(mm_req.wdata) && nv_wr.wr &&
         nv_wr.addr == LDR_ADDR_SEL)
      else $error("select byte write not stored");

   index_persist_a: assert property (
      mm_req.wr && !restore_valid && write_permit_latch &&
         mm_req.addr == LDR_ADDR_ROW1 |=>
         nv_wr.wr == $past(control_bytes_persistence) &&
         nv_wr.data == {2'h0, $past(mm_req.wdata[5:0])})
      else $error("index persistence wrong");

   reserved_write_a: assert property (
      mm_req.wr && !restore_valid && write_permit_latch &&
         mm_req.addr >= LDR_ADDR_RSV_LO && mm_req.addr <= LDR_ADDR_RSV_HI
         |=> mm_resp.ack && !nv_wr.wr && $stable(s_q.ctl) &&
         $stable(write_permit_latch))
      else $error("reserved address write had an effect");

endmodule
